/* File: hw/irab_top.sv */
// indirect register access bridge: wishbone slave, analog and apb paths
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`include "irab_consts.svh"
module irab_top import irab_pkg::*; (
  // system
  input wire logic clk,
  input wire logic reset,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // analog indirect port
  output logic [4:0] ana_target,
  output logic [7:0] ana_addr,
  output logic [7:0] ana_wdata,
  output logic ana_wr,
  output logic ana_rd,
  input wire logic [7:0] ana_rdata,
  // apb bridge
  output logic [1:0] apb_target,
  output logic apb_psel,
  output logic apb_penable,
  output logic apb_pwrite,
  output logic [15:0] apb_paddr,
  output logic [31:0] apb_pwdata,
  input wire logic [31:0] apb_prdata,
  input wire logic apb_pready
);
  irab_top_s s_q;
  irab_top_s s_d;
  logic go;
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [7:0] pofs;
  logic [1:0] pbyte;
  logic hit_actl;
  logic hit_off;
  logic hit_adat;
  logic hit_pctl;
  logic hit_pad0;
  logic hit_pad1;
  logic hit_pdat;
  logic [2:0] asel;
  logic aon;
  logic ainc;
  logic apre;
  logic ana_wr_go;
  logic ana_rd_go;
  logic ana_step;
  logic [7:0] off_nx;
  logic [7:0] ana_adr_src;
  logic [1:0] ptgt;
  logic pon;
  logic pinc;
  logic pro;
  logic p_ready;
  logic p_done;
  logic p_done_rd;
  logic launch_rd;
  logic launch_wr;
  logic [7:0] rmux;

  // bus decode; one access per request, ack follows one cycle later
  assign go = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign wr = go & wb_we_i & wb_sel_i[0];
  assign rd = go & ~wb_we_i;
  assign idx = wb_adr_i[9:2];
  assign wbyte = wb_dat_i[7:0];
  assign hit_actl = idx == `IRAB_IDX_ANA_CTL;
  assign hit_off = idx == `IRAB_IDX_ANA_OFF;
  assign hit_adat = idx == `IRAB_IDX_ANA_DAT;
  assign hit_pctl = idx == `IRAB_IDX_BUS_BRIDGE_CONTROL;
  assign hit_pad0 = idx == `IRAB_IDX_APB_AD0; // [R13]
  assign hit_pad1 = idx == `IRAB_IDX_APB_AD1; // [R13]
  assign hit_pdat = (idx >= `IRAB_IDX_APB_DT0) &&
                    (idx <= `IRAB_IDX_APB_DT3); // [R14]
  assign pofs = idx - `IRAB_IDX_APB_DT0;
  assign pbyte = pofs[1:0];

  // analog indirect path
  assign asel = s_q.actl[`IRAB_ANA_SEL_HI:`IRAB_ANA_SEL_LO]; // [R1]
  assign aon = asel != `IRAB_SEL_OFF; // [R15]
  assign ainc = s_q.actl[`IRAB_ANA_INC];
  assign apre = s_q.actl[`IRAB_ANA_PRE];
  assign ana_wr_go = wr & hit_adat & aon; // [R6] [R15]
  assign ana_step = aon & ainc & (ana_wr_go | (rd & hit_adat)); // [R2]
  always_comb begin
    off_nx = s_q.off;
    if (wr & hit_off) begin
      off_nx = wbyte; // [R5]
    end else if (ana_step) begin
      off_nx = s_q.off + `IRAB_ANA_STEP; // [R2]
    end
  end
  // prefetch strobes carry the offset that the next access will use
  assign ana_rd_go = aon & apre &
                     ((wr & hit_off) | (rd & hit_adat & ainc)); // [R3] [R4]
  assign ana_adr_src = ana_wr_go ? s_q.off : off_nx; // [R6]

  // apb bridge path
  assign ptgt = s_q.pctl[`IRAB_APB_SEL_HI:`IRAB_APB_SEL_LO];
  assign pon = s_q.pctl[`IRAB_APB_EN];
  assign pinc = s_q.pctl[`IRAB_APB_INC];
  assign pro = ptgt[1];
  // the enable may be set in the same write that launches the read
  assign launch_rd = wr & hit_pctl & wbyte[`IRAB_APB_RD] &
                     wbyte[`IRAB_APB_EN] & p_ready; // [R10] [R12]
  // the top data byte completes a word and sends it out
  assign launch_wr = wr & hit_pdat & (pbyte == 2'h3) & pon & ~pro &
                     p_ready; // [R12] [R16]

  // read data mux
  always_comb begin
    rmux = `IRAB_RST_BYTE;
    if (hit_actl) begin
      rmux = s_q.actl;
    end else if (hit_off) begin
      rmux = s_q.off;
    end else if (hit_adat) begin
      rmux = aon ? ana_rdata : `IRAB_RST_BYTE; // [R7] [R15]
    end else if (hit_pctl) begin
      rmux = s_q.pctl;
    end else if (hit_pad0) begin
      rmux = s_q.padr[7:0];
    end else if (hit_pad1) begin
      rmux = s_q.padr[15:8];
    end else if (hit_pdat) begin
      rmux = s_q.pdat[{pbyte, 3'h0} +: 8]; // [R14]
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.ack = go;
    if (rd) begin
      s_d.dat = rmux;
    end
    if (wr & hit_actl) begin
      s_d.actl = wbyte;
    end
    s_d.off = off_nx;
    if (wr & hit_pctl) begin
      s_d.pctl = wbyte & `IRAB_BUS_BRIDGE_CONTROL_MASK;
      // a running read cannot be cancelled by writing zero
      s_d.pctl[`IRAB_APB_RD] = launch_rd | s_q.pctl[`IRAB_APB_RD];
    end
    if (p_done & pinc) begin
      s_d.padr = s_q.padr + irab_step(apb_target); // [R9]
    end
    // a software address write beats the automatic step
    if (wr & hit_pad0) begin
      s_d.padr[7:0] = wbyte; // [R13]
    end
    if (wr & hit_pad1) begin
      s_d.padr[15:8] = wbyte; // [R13]
    end
    if (wr & hit_pdat) begin
      s_d.pdat[{pbyte, 3'h0} +: 8] = wbyte; // [R14]
    end
    if (p_done_rd) begin
      s_d.pdat = apb_prdata; // [R10]
      if (!launch_rd) begin
        s_d.pctl[`IRAB_APB_RD] = 1'b0; // [R10]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = {24'h0, s_q.dat};

  irab_ana_port i_irab_ana_port (
    .clk(clk),
    .reset(reset),
    .sel(asel),
    .wr_go(ana_wr_go),
    .rd_go(ana_rd_go),
    .addr(ana_adr_src),
    .wdata(wbyte),
    .ana_target(ana_target),
    .ana_addr(ana_addr),
    .ana_wdata(ana_wdata),
    .ana_wr(ana_wr),
    .ana_rd(ana_rd)
  );

  irab_apb_master i_irab_apb_master (
    .clk(clk),
    .reset(reset),
    .start(launch_rd | launch_wr),
    .write(launch_wr),
    .target(s_d.pctl[`IRAB_APB_SEL_HI:`IRAB_APB_SEL_LO]), // [R8]
    .addr(s_d.padr),
    .wdata({wbyte, s_q.pdat[23:0]}),
    .ready(p_ready),
    .done(p_done),
    .done_read(p_done_rd),
    .apb_target(apb_target),
    .apb_psel(apb_psel),
    .apb_penable(apb_penable),
    .apb_pwrite(apb_pwrite),
    .apb_paddr(apb_paddr),
    .apb_pwdata(apb_pwdata),
    .apb_pready(apb_pready)
  );

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_launch;
    wr && hit_pctl && wbyte[`IRAB_APB_RD] && wbyte[`IRAB_APB_EN] &&
      p_ready;
  endsequence
  sequence s_phase;
    apb_psel && !apb_penable ##1 apb_psel && apb_penable;
  endsequence
  sequence s_bus_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_bus_ack:
    assert property (go |=> s_bus_answer)
    else $error("bus ack not a single pulse");
  a_ana_all: // [R1]
    assert property (asel == `IRAB_SEL_ALL |=> ana_target == 5'h07)
    else $error("simultaneous select not on three channels");
  a_ana_step: // [R2]
    assert property (ana_wr_go && ainc |=>
      s_q.off == $past(s_q.off) + 8'h01)
    else $error("analog offset did not step");
  a_pre_offset: // [R3]
    assert property (wr && hit_off && aon && apre |=>
      ana_rd && ana_addr == $past(wbyte))
    else $error("no prefetch strobe on offset write");
  a_pre_data: // [R4]
    assert property (rd && hit_adat && aon && apre && ainc |=>
      ana_rd && ana_addr == $past(s_q.off) + 8'h01)
    else $error("no prefetch strobe on data read");
  a_off_hold: // [R5]
    assert property (!(wr && hit_off) && !ana_step |=> $stable(s_q.off))
    else $error("analog offset moved");
  a_ana_write: // [R6]
    assert property (ana_wr_go |=> ana_wr &&
      ana_wdata == $past(wbyte) && ana_addr == $past(s_q.off))
    else $error("indirect write wrong");
  a_ana_read: // [R7]
    assert property (rd && hit_adat && aon |=>
      wb_ack_o && wb_dat_o[7:0] == $past(ana_rdata))
    else $error("indirect read data wrong");
  a_apb_target: // [R8]
    assert property (s_launch |=>
      apb_target == $past(wbyte[`IRAB_APB_SEL_HI:`IRAB_APB_SEL_LO]))
    else $error("bridge target wrong");
  a_apb_step: // [R9]
    assert property (p_done && pinc && !(wr && (hit_pad0 || hit_pad1))
      |=> s_q.padr == $past(s_q.padr) +
      (($past(apb_target) == 2'h0) ? 16'h0004 : 16'h0001))
    else $error("bridge address step wrong");
  a_apb_launch: // [R10]
    assert property (s_launch |=> s_phase)
    else $error("launch gave no apb read");
  a_launch_clear: // [R10]
    assert property (p_done_rd && !launch_rd |=>
      !s_q.pctl[`IRAB_APB_RD] && s_q.pdat == $past(apb_prdata))
    else $error("launch bit not cleared with data");
  a_bridge_off: // [R12]
    assert property (!pon && !(wr && hit_pctl) && !apb_psel |=>
      !apb_psel)
    else $error("disabled bridge started a transfer");
  a_addr_byte: // [R13]
    assert property (wr && hit_pad1 |=> s_q.padr[15:8] == $past(wbyte))
    else $error("address high byte not stored");
  a_data_byte: // [R14]
    assert property (rd && hit_pdat && pbyte == 2'h3 |=>
      wb_dat_o[7:0] == $past(s_q.pdat[31:24]))
    else $error("data top byte read wrong");
  a_ana_quiet: // [R15]
    assert property (!aon |=> !ana_wr && !ana_rd)
    else $error("strobe while analog path off");
  a_ana_zero: // [R15]
    assert property (rd && hit_adat && !aon |=> wb_dat_o == 32'h0)
    else $error("disabled data read not zero");
  a_ro_guard: // [R16]
    assert property (wr && hit_pdat && pon && pro && !apb_psel |=>
      !apb_psel)
    else $error("write sent to read-only target");
  a_ack_idle:
    assert property (!go |=> !wb_ack_o)
    else $error("bus ack without a request");
  a_dat_hold:
    assert property (!rd |=> $stable(wb_dat_o))
    else $error("read data moved without a read");
  a_ana_tx: // [R1]
    assert property (asel == 3'h5 |=> ana_target == 5'h10)
    else $error("transmitter select not on its own bank");
  a_off_load: // [R5]
    assert property (wr && hit_off |=> s_q.off == $past(wbyte))
    else $error("analog offset not loaded");
  a_wr_pulse: // [R6]
    assert property (ana_wr |=> !ana_wr)
    else $error("indirect write strobe too long");
  // a slow slave must see the same request until it answers
  sequence s_apb_wait;
    apb_psel && apb_penable && !apb_pready;
  endsequence
  a_apb_hold:
    assert property (s_apb_wait |=> apb_psel && apb_penable &&
      $stable(apb_paddr) && $stable(apb_pwrite) && $stable(apb_pwdata))
    else $error("apb request changed before ready");
  a_apb_write: // [R14] [R16]
    assert property (wr && hit_pdat && pbyte == 2'h3 && pon && !pro &&
      p_ready |=> apb_psel && apb_pwrite &&
      apb_pwdata == {$past(wbyte), $past(s_q.pdat[23:0])})
    else $error("bridge write word wrong");
  a_read_addr: // [R10]
    assert property (s_launch ##0 !p_done |=> !apb_pwrite &&
      apb_paddr == $past(s_q.padr))
    else $error("bridge read address wrong");
  a_launch_set: // [R10]
    assert property (s_launch |=> s_q.pctl[`IRAB_APB_RD])
    else $error("launch bit not held while reading");
  a_step_hold: // [R9]
    assert property (!p_done && !(wr && (hit_pad0 || hit_pad1)) |=>
      $stable(s_q.padr))
    else $error("bridge address moved");
  a_ctl_spare: // [R12]
    assert property (wr && hit_pctl |=> s_q.pctl[7:5] == 3'h0 &&
      s_q.pctl[`IRAB_APB_EN] == $past(wbyte[`IRAB_APB_EN]))
    else $error("bridge control stored wrong");
  a_unmapped:
    assert property (rd && !(hit_actl || hit_off || hit_adat || hit_pctl ||
      hit_pad0 || hit_pad1 || hit_pdat) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule

/* File: hw/irab_consts.svh */
// constants of the indirect register access bridge
// Function
// R1 - analog target field bits 4:2: off, channels 0-2, shared, transmitter, all three
// R2 - analog offset steps by one after each indirect access when autostep is on
// R3 - prefetch on: writing the offset sends a read strobe to the target
// R4 - prefetch and autostep on: reading the data port also sends a read strobe
// R5 - an 8-bit offset picks the register inside the analog target
// R6 - writing the data port writes the byte to the target at the offset
// R7 - reading the data port returns the target register at the offset
// R8 - bridge target field bits 4:3: controller, edid sram, config, die id
// R9 - bridge autostep adds 4 for the controller target, else 1
// R10 - writing one to the launch bit starts a read, cleared when done
// R11 - software should load both address bytes before launching a read
// R12 - bridge works only while its enable bit 0 is set
// R13 - 16-bit bridge address in two bytes, low at 0x49, high at 0x4a
// R14 - 32-bit bridge data in four bytes 0x4b to 0x4e, low first
// R15 - target off: data writes ignored, no strobes, data reads give zero
// R16 - writes to read-only bridge targets change nothing
`ifndef IRAB_CONSTS_SVH
`define IRAB_CONSTS_SVH
`define IRAB_IDX_ANA_CTL 8'h40
`define IRAB_IDX_ANA_OFF 8'h41
`define IRAB_IDX_ANA_DAT 8'h42
`define IRAB_IDX_BUS_BRIDGE_CONTROL 8'h48
`define IRAB_IDX_APB_AD0 8'h49
`define IRAB_IDX_APB_AD1 8'h4a
`define IRAB_IDX_APB_DT0 8'h4b
`define IRAB_IDX_APB_DT3 8'h4e
`define IRAB_ANA_SEL_HI 4
`define IRAB_ANA_SEL_LO 2
`define IRAB_ANA_INC 1
`define IRAB_ANA_PRE 0
`define IRAB_APB_SEL_HI 4
`define IRAB_APB_SEL_LO 3
`define IRAB_APB_INC 2
`define IRAB_APB_RD 1
`define IRAB_APB_EN 0
`define IRAB_BUS_BRIDGE_CONTROL_MASK 8'h1f
`define IRAB_RST_BYTE 8'h00
`define IRAB_ANA_STEP 8'h01
`define IRAB_STEP_CTRL 16'h0004
`define IRAB_STEP_OTHER 16'h0001
`define IRAB_SEL_OFF 3'h0
`define IRAB_SEL_ALL 3'h6
`define IRAB_TGT_CTRL 2'h0
`endif

/* File: hw/irab_pkg.sv */
// types and decode helpers of the indirect register access bridge
`include "irab_consts.svh"
package irab_pkg;
  typedef enum logic [1:0] {AP_IDLE, AP_SETUP, AP_ACCESS} irab_apb_st_e;
  typedef struct packed {
    irab_apb_st_e st;
    logic wr;
    logic [1:0] tgt;
    logic [15:0] adr;
    logic [31:0] wd;
  } irab_apb_s;
  typedef struct packed {
    logic [4:0] tgt;
    logic [7:0] adr;
    logic [7:0] wd;
    logic wr;
    logic rd;
  } irab_ana_s;
  typedef struct packed {
    logic ack;
    logic [7:0] dat;
    logic [7:0] actl;
    logic [7:0] off;
    logic [7:0] pctl;
    logic [15:0] padr;
    logic [31:0] pdat;
  } irab_top_s;
  function automatic logic [4:0] irab_ana_hot(input logic [2:0] sel);
    unique case (sel)
      3'h1: irab_ana_hot = 5'h01;
      3'h2: irab_ana_hot = 5'h02;
      3'h3: irab_ana_hot = 5'h04;
      3'h4: irab_ana_hot = 5'h08;
      3'h5: irab_ana_hot = 5'h10;
      `IRAB_SEL_ALL: irab_ana_hot = 5'h07;
      default: irab_ana_hot = 5'h00;
    endcase
  endfunction
  function automatic logic [15:0] irab_step(input logic [1:0] tgt);
    irab_step = (tgt == `IRAB_TGT_CTRL) ? `IRAB_STEP_CTRL : `IRAB_STEP_OTHER;
  endfunction
endpackage

/* File: hw/irab_ana_port.sv */
// registered strobe and address drive toward the analog blocks
`timescale 1ns/1ps
module irab_ana_port import irab_pkg::*; (
  // system
  input wire logic clk,
  input wire logic reset,
  // requests from the register side
  input wire logic [2:0] sel,
  input wire logic wr_go,
  input wire logic rd_go,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  // analog side
  output logic [4:0] ana_target,
  output logic [7:0] ana_addr,
  output logic [7:0] ana_wdata,
  output logic ana_wr,
  output logic ana_rd
);
  irab_ana_s s_q;
  irab_ana_s s_d;
  always_comb begin
    s_d = s_q;
    s_d.tgt = irab_ana_hot(sel); // [R1]
    s_d.adr = addr;
    s_d.wr = wr_go;
    s_d.rd = rd_go;
    if (wr_go) begin
      s_d.wd = wdata;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign ana_target = s_q.tgt;
  assign ana_addr = s_q.adr;
  assign ana_wdata = s_q.wd;
  assign ana_wr = s_q.wr;
  assign ana_rd = s_q.rd;
endmodule

/* File: hw/irab_apb_master.sv */
// two-phase apb master of the bridge path
`timescale 1ns/1ps
module irab_apb_master import irab_pkg::*; (
  // system
  input wire logic clk,
  input wire logic reset,
  // requests from the register side
  input wire logic start,
  input wire logic write,
  input wire logic [1:0] target,
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  output logic ready,
  output logic done,
  output logic done_read,
  // apb side
  output logic [1:0] apb_target,
  output logic apb_psel,
  output logic apb_penable,
  output logic apb_pwrite,
  output logic [15:0] apb_paddr,
  output logic [31:0] apb_pwdata,
  input wire logic apb_pready
);
  irab_apb_s s_q;
  irab_apb_s s_d;
  assign apb_psel = s_q.st != AP_IDLE;
  assign apb_penable = s_q.st == AP_ACCESS;
  assign apb_pwrite = s_q.wr;
  assign apb_paddr = s_q.adr;
  assign apb_pwdata = s_q.wd;
  assign apb_target = s_q.tgt;
  assign done = apb_penable & apb_pready;
  assign done_read = done & ~s_q.wr;
  // a new request may start in the cycle the last one completes
  assign ready = (s_q.st == AP_IDLE) | done;
  always_comb begin
    s_d = s_q;
    unique case (s_q.st)
      AP_IDLE: begin
        s_d.st = AP_IDLE;
      end
      AP_SETUP: begin
        s_d.st = AP_ACCESS;
      end
      AP_ACCESS: begin
        if (apb_pready) begin
          s_d.st = AP_IDLE;
        end
      end
    endcase
    if (start & ready) begin
      s_d.st = AP_SETUP;
      s_d.wr = write;
      s_d.tgt = target; // [R8]
      s_d.adr = addr;
      s_d.wd = wdata;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

/* File: verif/irab_far_model.sv */
// far side model: analog register banks and apb slave targets
`timescale 1ns/1ps
module irab_far_model (
  // system
  input wire logic clk,
  input wire logic slow,
  // analog blocks
  input wire logic [4:0] ana_target,
  input wire logic [7:0] ana_addr,
  input wire logic [7:0] ana_wdata,
  input wire logic ana_wr,
  output logic [7:0] ana_rdata,
  // apb slaves
  input wire logic [1:0] apb_target,
  input wire logic apb_psel,
  input wire logic apb_penable,
  input wire logic apb_pwrite,
  input wire logic [15:0] apb_paddr,
  input wire logic [31:0] apb_pwdata,
  output logic [31:0] apb_prdata,
  output logic apb_pready
);
  logic [7:0] bank [5][256];
  logic [31:0] mem [4][16];
  int wait_q = 0;
  initial begin
    for (int i = 0; i < 5; i++)
      for (int a = 0; a < 256; a++)
        bank[i][a] = 8'(a + 32 * i);
    for (int t = 0; t < 4; t++)
      for (int k = 0; k < 16; k++)
        mem[t][k] = {8'(t), 8'(k), 16'hc3a5};
  end
  // no target selected: nothing drives, show a changing value
  always_comb begin
    ana_rdata = ~ana_addr;
    for (int i = 4; i >= 0; i--)
      if (ana_target[i])
        ana_rdata = bank[i][ana_addr];
  end
  assign apb_pready = apb_psel && apb_penable && (wait_q >= (slow ? 2 : 0));
  assign apb_prdata = apb_pready ? mem[apb_target][apb_paddr[3:0]] :
                      {apb_paddr, ~apb_paddr};
  // stores even to read-only targets, so a stray write shows up
  always @(posedge clk) begin
    wait_q <= (apb_psel && apb_penable && !apb_pready) ? wait_q + 1 : 0;
    for (int i = 0; i < 5; i++)
      if (ana_wr && ana_target[i])
        bank[i][ana_addr] <= ana_wdata;
    if (apb_pready && apb_pwrite)
      mem[apb_target][apb_paddr[3:0]] <= apb_pwdata;
  end
endmodule

/* File: verif/irab_bench.sv */
// self-checking bench of the indirect register access bridge
`timescale 1ns/1ps
module irab_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic slow = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o, apb_pwdata, apb_prdata, xf_d, d;
  logic wb_ack_o, ana_wr, ana_rd, apb_psel, apb_penable, apb_pwrite;
  logic apb_pready, xf_w;
  logic [4:0] ana_target, wr_t;
  logic [7:0] ana_addr, ana_wdata, ana_rdata, rd_a, wr_a;
  logic [1:0] apb_target;
  logic [15:0] apb_paddr, xf_a;
  logic [4:0] hot [7] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h07};
  int errors = 0;
  int total_checks = 0;
  int cyc_n = 0, rd_n = 0, wr_n = 0, xf_n = 0;
  irab_top i_irab_top (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ana_target,
    .ana_addr, .ana_wdata, .ana_wr, .ana_rd, .ana_rdata, .apb_target,
    .apb_psel, .apb_penable, .apb_pwrite, .apb_paddr, .apb_pwdata,
    .apb_prdata, .apb_pready);
  irab_far_model i_irab_far_model (.clk, .slow, .ana_target, .ana_addr,
    .ana_wdata, .ana_wr, .ana_rdata, .apb_target, .apb_psel, .apb_penable,
    .apb_pwrite, .apb_paddr, .apb_pwdata, .apb_prdata, .apb_pready);
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      errors++;
      give_verdict();
    end
  end
  // strobes are single-cycle, so they are caught at the edge
  always @(posedge clk) begin
    if (ana_rd === 1'b1) begin
      rd_n++;
      rd_a = ana_addr;
    end
    if (ana_wr === 1'b1) begin
      wr_n++;
      wr_a = ana_addr;
      wr_t = ana_target;
    end
    if (apb_psel && apb_penable && apb_pready) begin
      xf_n++;
      xf_a = apb_paddr;
      xf_d = apb_pwdata;
      xf_w = apb_pwrite;
    end
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic we, input logic [7:0] ix,
                      input logic [7:0] wd, output logic [7:0] rv);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {ix, 2'h0};
    wb_dat_i <= {24'h000000, wd};
    @(posedge clk);
    // only the run timeout ends this wait
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk);
    end
    rv = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] wd);
    logic [7:0] junk;
    xfer(1'b1, ix, wd, junk);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] ix,
                       input logic [7:0] e);
    logic [7:0] g;
    xfer(1'b0, ix, 8'h00, g);
    chk(nm, 32'(e), 32'(g));
  endtask
  task automatic apb_rd(input logic [7:0] ctl, input logic [15:0] a);
    int n;
    logic [7:0] b;
    wr(8'h48, ctl);
    wr(8'h49, a[7:0]);
    wr(8'h4a, a[15:8]);
    wr(8'h48, ctl | 8'h02);
    n = 0;
    b = 8'h02;
    while (b[1] !== 1'b0 && n < 20) begin
      xfer(1'b0, 8'h48, 8'h00, b);
      n++;
    end
    chk("launch poll", 32'h0, 32'(b[1]));
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 8'h4b + 8'(i), 8'h00, b);
      d[8*i +: 8] = b;
    end
  endtask
  task automatic wait_xf(input int b);
    for (int n = 0; n < 20 && xf_n == b; n++)
      @(posedge clk);
  endtask
  initial begin
    int b;
    logic [7:0] ix [11];
    ix = '{8'h40, 8'h41, 8'h42, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h4d,
           8'h4e, 8'h50};
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (ix[i]) rdchk("reset value", ix[i], 8'h00);
    wr(8'h50, 8'h77);
    rdchk("unmapped", 8'h50, 8'h00);
    for (int s = 1; s < 7; s++) begin
      wr(8'h40, 8'(s << 2));
      wr(8'h41, 8'h20);
      wr(8'h42, 8'(8'h30 + s));
      chk("target", 32'(hot[s]), 32'(wr_t));
      chk("wr offset", 32'h20, 32'(wr_a));
      rdchk("data back", 8'h42, 8'(8'h30 + s));
    end
    chk("no prefetch", 32'h0, 32'(rd_n));
    wr(8'h40, 8'h07);
    b = rd_n;
    wr(8'h41, 8'hff);
    chk("pre strobe", 32'(b + 1), 32'(rd_n));
    chk("pre addr", 32'hff, 32'(rd_a));
    wr(8'h42, 8'h5a);
    chk("wr addr", 32'hff, 32'(wr_a));
    rdchk("offset wrap", 8'h41, 8'h00);
    wr(8'h41, 8'hff);
    b = rd_n;
    rdchk("data", 8'h42, 8'h5a);
    chk("read strobe", 32'(b + 1), 32'(rd_n));
    chk("read addr", 32'h00, 32'(rd_a));
    wr(8'h40, 8'he3);
    rdchk("ctl spare", 8'h40, 8'he3);
    b = wr_n + rd_n;
    wr(8'h41, 8'h10);
    wr(8'h42, 8'h99);
    rdchk("off data", 8'h42, 8'h00);
    chk("off strobes", 32'(b), 32'(wr_n + rd_n));
    rdchk("off no step", 8'h41, 8'h10);
    wb_sel_i <= 4'he;
    wr(8'h41, 8'h33);
    wb_sel_i <= 4'hf;
    rdchk("sel lane", 8'h41, 8'h10);
    // slow slave first, then prompt answers
    slow <= 1'b1;
    wr(8'h48, 8'h05);
    wr(8'h49, 8'h04);
    wr(8'h4a, 8'h00);
    b = xf_n;
    for (int i = 0; i < 4; i++)
      wr(8'h4b + 8'(i), 8'(8'h11 * (i + 1)));
    wait_xf(b);
    chk("apb wr data", 32'h44332211, xf_d);
    chk("apb wr addr", 32'h0004, 32'(xf_a));
    chk("apb wr dir", 32'h1, 32'(xf_w));
    rdchk("step ctrl", 8'h49, 8'h08);
    apb_rd(8'h05, 16'h0004);
    chk("apb rd", 32'h44332211, d);
    chk("apb rd dir", 32'h0, 32'(xf_w));
    rdchk("launch clear", 8'h48, 8'h05);
    rdchk("step ctrl rd", 8'h49, 8'h08);
    slow <= 1'b0;
    for (int t = 1; t < 4; t++) begin
      apb_rd(8'((t << 3) | 5), 16'h0003);
      chk("apb target", {8'(t), 8'h03, 16'hc3a5}, d);
      rdchk("step other", 8'h49, 8'h04);
    end
    wr(8'h48, 8'h15);
    b = xf_n;
    for (int i = 0; i < 4; i++)
      wr(8'h4b + 8'(i), 8'h66);
    wait_xf(b);
    chk("ro no xfer", 32'(b), 32'(xf_n));
    apb_rd(8'h15, 16'h0004);
    chk("ro kept", {8'h02, 8'h04, 16'hc3a5}, d);
    wr(8'h48, 8'h04);
    b = xf_n;
    wr(8'h4e, 8'h55);
    wr(8'h48, 8'h06);
    wait_xf(b);
    chk("disabled", 32'(b), 32'(xf_n));
    rdchk("no launch", 8'h48, 8'h04);
    give_verdict();
  end
endmodule
